/* File: ttm_cfg.svh */
// Register field positions, write masks and reset values of the thermal monitor
`ifndef TTM_CFG_SVH
`define TTM_CFG_SVH
// Threshold register fields
`define TTM_THR_ARM 0
`define TTM_THR_IE 1
`define TTM_THR_DIR 2
`define TTM_THR_VAL_LSB 4
`define TTM_THR_VAL_MSB 10
`define TTM_THR_VLD 30
`define TTM_THR_RES 31
`define TTM_THR_WMASK 32'h0000_07F7
`define TTM_THR_RST 32'h0000_0000
// Control register fields
`define TTM_CTL_EN 0
`define TTM_CTL_SIT_LSB 1
`define TTM_CTL_SIT_MSB 13
`define TTM_CTL_WMASK 32'h0000_3FFF
`define TTM_CTL_RST 32'h0000_0000
// Fetch throttle register fields
`define TTM_THROT_EN 0
`define TTM_THROT_INT_LSB 1
`define TTM_THROT_INT_MSB 8
`define TTM_THROT_WMASK 32'h0000_01FF
`define TTM_THROT_RST 32'h0000_0000
`endif

/* File: ttm_pkg.sv */
// Types shared by the thermal monitor
package ttm_pkg;
    typedef enum logic [2:0] {
        TTM_IDLE = 3'b001,
        TTM_SAMPLE = 3'b010,
        TTM_DONE = 3'b100
    } ttm_state_t;
    typedef enum logic [1:0] {
        TTM_SEL_A = 2'h0,
        TTM_SEL_B = 2'h1,
        TTM_SEL_CTL = 2'h2,
        TTM_SEL_THROT = 2'h3
    } ttm_spr_t;
endpackage

/* File: ttm_sensor_model.sv */
// Behavioural junction sensor and comparator facing the monitor
module ttm_sensor_model (
    // Threshold from the DAC
    input wire logic [6:0] dacCode,
    // Simulated junction temperature
    input wire logic [6:0] temperature,
    // Comparator result
    output logic cmpOut
);
    timeunit 1ns;
    timeprecision 1ps;
    // High while the junction is above the DAC level
    assign cmpOut = (temperature > dacCode);
endmodule

/* File: ttm_thermal_threshold_monitor.sv */
// Thermal threshold monitor: threshold registers, comparator sequencing, fetch throttle
`include "ttm_cfg.svh"

// Behaviour
// - Sensor comparator checks junction temperature against software-programmed thresholds.
// - Threshold crossing with interrupt enabled raises a thermal exception pulse.
// - Two independent threshold registers, each checked against its own limit.
// - With one threshold armed, only that register drives the comparator.
// - With both armed, comparisons alternate between them, each raising exceptions.
// - Control register holds facility enable and comparator sample interval.
// - All thermal registers accessible only at supervisor level via special-register moves.
// - Software may rewrite thresholds and read results for successive approximation.
// - Throttle register sets the interval between instruction fetch grants.
module ttm_thermal_threshold_monitor #(
    parameter int VAL_W = 7,
    parameter int SIT_W = 13,
    parameter int INT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Special-purpose register moves
    input wire logic sprWrEn,
    input wire logic sprRdEn,
    input wire ttm_pkg::ttm_spr_t sprSel,
    input wire logic [31:0] sprWrData,
    input wire logic supervisor,
    output logic [31:0] sprRdData,
    output logic sprFault,
    // Analog sensor side
    output logic [VAL_W-1:0] dacCode,
    input wire logic cmpOut,
    // Exception and fetch pacing
    output logic thermalExc,
    output logic fetchGrant
);
    import ttm_pkg::*;

    // ==========================================
    // Reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] thrWrite(input logic [31:0] data);
        thrWrite = data & `TTM_THR_WMASK;
    endfunction

    function automatic logic tempBeyond(input logic dir, input logic cmp);
        // Dir set: alarm when temperature is at or below the threshold
        tempBeyond = dir ? !cmp : cmp;
    endfunction

    // ==========================================
    // State
    logic [31:0] thrA;
    logic [31:0] thrB;
    logic [31:0] ctl;
    logic [31:0] throt;
    ttm_state_t state;
    logic chan;
    logic [SIT_W-1:0] sampleCnt;
    logic [INT_W-1:0] throtCnt;
    logic [31:0] next_thrA;
    logic [31:0] next_thrB;
    logic [31:0] next_ctl;
    logic [31:0] next_throt;
    ttm_state_t next_state;
    logic next_chan;
    logic [SIT_W-1:0] next_sampleCnt;
    logic [INT_W-1:0] next_throtCnt;
    logic [31:0] next_sprRdData;
    logic next_sprFault;
    logic [VAL_W-1:0] next_dacCode;
    logic next_thermalExc;
    logic next_fetchGrant;

    logic enable;
    logic armA;
    logic armB;
    logic wrOk;
    logic hit;
    logic chanIe;
    logic chanDir;
    logic chanArm;
    logic chanWritten;
    logic launchChan;
    logic launchWritten;
    logic [SIT_W-1:0] sitVal;
    logic [SIT_W-1:0] sitLimit;
    logic [INT_W-1:0] throtInt;

    assign enable = ctl[`TTM_CTL_EN];
    assign armA = thrA[`TTM_THR_ARM];
    assign armB = thrB[`TTM_THR_ARM];
    assign wrOk = sprWrEn && supervisor;
    assign sitVal = ctl[`TTM_CTL_SIT_MSB:`TTM_CTL_SIT_LSB];
    assign sitLimit = (sitVal == '0) ? '0 : sitVal - SIT_W'(1);
    assign throtInt = throt[`TTM_THROT_INT_MSB:`TTM_THROT_INT_LSB];
    assign chanIe = chan ? thrB[`TTM_THR_IE] : thrA[`TTM_THR_IE];
    assign chanDir = chan ? thrB[`TTM_THR_DIR] : thrA[`TTM_THR_DIR];
    assign chanArm = chan ? armB : armA;
    assign chanWritten = wrOk && (sprSel == (chan ? TTM_SEL_B : TTM_SEL_A));
    assign hit = tempBeyond(chanDir, cmpOut);
    assign launchChan = (armA && armB) ? !chan : armB;
    assign launchWritten = wrOk && (sprSel == (launchChan ? TTM_SEL_B : TTM_SEL_A));

    // ==========================================
    // Next-state logic
    always_comb begin
        next_thrA = thrA;
        next_thrB = thrB;
        next_ctl = ctl;
        next_throt = throt;
        next_state = state;
        next_chan = chan;
        next_sampleCnt = sampleCnt;
        next_dacCode = dacCode;
        next_thermalExc = 1'b0;
        next_sprRdData = 32'h0000_0000;
        next_sprFault = (sprWrEn || sprRdEn) && !supervisor;
        // Register moves, supervisor only
        if (wrOk) begin
            unique case (sprSel)
                TTM_SEL_A: next_thrA = thrWrite(sprWrData);
                TTM_SEL_B: next_thrB = thrWrite(sprWrData);
                TTM_SEL_CTL: next_ctl = sprWrData & `TTM_CTL_WMASK;
                TTM_SEL_THROT: next_throt = sprWrData & `TTM_THROT_WMASK;
            endcase
        end
        if (sprRdEn && supervisor) begin
            unique case (sprSel)
                TTM_SEL_A: next_sprRdData = thrA;
                TTM_SEL_B: next_sprRdData = thrB;
                TTM_SEL_CTL: next_sprRdData = ctl;
                TTM_SEL_THROT: next_sprRdData = throt;
            endcase
        end
        // Comparator sequencing
        if (!enable) begin
            next_state = TTM_IDLE;
        end else begin
            unique case (state)
                TTM_IDLE: begin
                    // Launch waits a cycle while its threshold is rewritten, so a sample never runs on a stale DAC value
                    if ((armA || armB) && !launchWritten) begin
                        next_chan = launchChan;
                        next_dacCode = launchChan ? thrB[`TTM_THR_VAL_MSB:`TTM_THR_VAL_LSB]
                                                  : thrA[`TTM_THR_VAL_MSB:`TTM_THR_VAL_LSB];
                        next_sampleCnt = '0;
                        next_state = TTM_SAMPLE;
                    end
                end
                TTM_SAMPLE: begin
                    // A rewritten or disarmed threshold abandons the sample
                    if (!chanArm || chanWritten) begin
                        next_state = TTM_IDLE;
                    end else if (sampleCnt == sitLimit) begin
                        next_state = TTM_DONE;
                    end else begin
                        next_sampleCnt = sampleCnt + SIT_W'(1);
                    end
                end
                TTM_DONE: begin
                    // Hardware set wins over a same-cycle software write
                    if (chan) begin
                        next_thrB[`TTM_THR_VLD] = 1'b1;
                        next_thrB[`TTM_THR_RES] = hit;
                    end else begin
                        next_thrA[`TTM_THR_VLD] = 1'b1;
                        next_thrA[`TTM_THR_RES] = hit;
                    end
                    next_thermalExc = hit && chanIe;
                    next_state = TTM_IDLE;
                end
                default: next_state = TTM_IDLE;
            endcase
        end
        // Fetch pacing
        next_throtCnt = '0;
        next_fetchGrant = 1'b1;
        if (throt[`TTM_THROT_EN]) begin
            next_fetchGrant = (throtCnt == throtInt);
            next_throtCnt = next_fetchGrant ? '0 : throtCnt + INT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            thrA <= `TTM_THR_RST;
            thrB <= `TTM_THR_RST;
            ctl <= `TTM_CTL_RST;
            throt <= `TTM_THROT_RST;
            state <= TTM_IDLE;
            chan <= 1'b1;
            sampleCnt <= '0;
            throtCnt <= '0;
            sprRdData <= 32'h0000_0000;
            sprFault <= 1'b0;
            dacCode <= '0;
            thermalExc <= 1'b0;
            fetchGrant <= 1'b0;
        end else begin
            thrA <= next_thrA;
            thrB <= next_thrB;
            ctl <= next_ctl;
            throt <= next_throt;
            state <= next_state;
            chan <= next_chan;
            sampleCnt <= next_sampleCnt;
            throtCnt <= next_throtCnt;
            sprRdData <= next_sprRdData;
            sprFault <= next_sprFault;
            dacCode <= next_dacCode;
            thermalExc <= next_thermalExc;
            fetchGrant <= next_fetchGrant;
        end
    end

    // ==========================================
    // Checks
    a_exc_needs_enable: assert property (@(posedge clk) disable iff (!rstSync)
        thermalExc |-> $past(enable))
        else $error("thermal exception while facility disabled");

    a_exc_has_cause: assert property (@(posedge clk) disable iff (!rstSync)
        thermalExc |-> $past(state == TTM_DONE) && $past(chanIe) && $past(hit))
        else $error("thermal exception without enabled crossing");

    a_user_write_ignored: assert property (@(posedge clk) disable iff (!rstSync)
        (sprWrEn && !supervisor && sprSel == TTM_SEL_CTL) |=> $stable(ctl))
        else $error("user-level write changed control register");

    a_user_access_faults: assert property (@(posedge clk) disable iff (!rstSync)
        ((sprWrEn || sprRdEn) && !supervisor) |=> sprFault && sprRdData == 32'h0000_0000)
        else $error("user-level access not refused");

    a_sample_length: assert property (@(posedge clk) disable iff (!rstSync)
        (state == TTM_DONE) |-> $past(state == TTM_SAMPLE) && $past(sampleCnt) == $past(sitLimit))
        else $error("sample interval not honoured");

    a_single_armed: assert property (@(posedge clk) disable iff (!rstSync)
        $rose(state == TTM_SAMPLE) |-> (chan ? armB : armA))
        else $error("comparison started on unarmed threshold");

    a_dual_alternate: assert property (@(posedge clk) disable iff (!rstSync)
        ($rose(state == TTM_SAMPLE) && $past(armA && armB)) |-> chan != $past(chan))
        else $error("dual mode did not alternate thresholds");

    a_dac_follows: assert property (@(posedge clk) disable iff (!rstSync)
        (state == TTM_SAMPLE) |-> dacCode == (chan ? thrB[`TTM_THR_VAL_MSB:`TTM_THR_VAL_LSB]
                                                    : thrA[`TTM_THR_VAL_MSB:`TTM_THR_VAL_LSB]))
        else $error("comparator threshold does not match register");

    a_result_flags: assert property (@(posedge clk) disable iff (!rstSync)
        (state == TTM_DONE && enable && !chan) |=> thrA[`TTM_THR_VLD] && thrA[`TTM_THR_RES] == $past(hit))
        else $error("threshold A result flags not recorded");

    a_throttle_gap: assert property (@(posedge clk) disable iff (!rstSync)
        (fetchGrant && throt[`TTM_THROT_EN] && throtInt != '0 && $past(throt[`TTM_THROT_EN])) |=> !fetchGrant)
        else $error("fetch grants not spaced by throttle interval");
endmodule

/* File: ttm_thermal_threshold_monitor_tb.sv */
// Self-checking testbench of the thermal threshold monitor
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module ttm_thermal_threshold_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ttm_pkg::*;
    logic clk = 0, rstn = 0, sprWrEn = 0, sprRdEn = 0, supervisor = 0;
    ttm_spr_t sprSel = TTM_SEL_A;
    logic [31:0] sprWrData = 32'h0, sprRdData;
    logic sprFault, cmpOut, thermalExc, fetchGrant;
    logic [6:0] dacCode, temperature = 7'h00;
    int mismatches = 0, n_tests = 0, excCount = 0;
    ttm_thermal_threshold_monitor ttm_thermal_threshold_monitor_i (.clk(clk), .rstn(rstn),
        .sprWrEn(sprWrEn), .sprRdEn(sprRdEn), .sprSel(sprSel), .sprWrData(sprWrData),
        .supervisor(supervisor), .sprRdData(sprRdData), .sprFault(sprFault), .dacCode(dacCode),
        .cmpOut(cmpOut), .thermalExc(thermalExc), .fetchGrant(fetchGrant));
    ttm_sensor_model ttm_sensor_model_i (.dacCode(dacCode), .temperature(temperature), .cmpOut(cmpOut));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (thermalExc === 1'b1) excCount++;
    end
    // ==========
    // Register moves
    task automatic wr(input ttm_spr_t s, input logic [31:0] d, input logic sup);
        @(negedge clk);
        sprWrEn = 1'b1;
        sprSel = s;
        sprWrData = d;
        supervisor = sup;
        @(negedge clk) sprWrEn = 1'b0;
        `CHK(sprFault, ~sup)
    endtask
    task automatic rd(input ttm_spr_t s, input logic [31:0] e, input logic sup);
        @(negedge clk);
        sprRdEn = 1'b1;
        sprSel = s;
        supervisor = sup;
        @(negedge clk) sprRdEn = 1'b0;
        `CHK(sprRdData, e)
        `CHK(sprFault, ~sup)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_access();
        logic [31:0] msk [4] = '{32'h7F7, 32'h7F7, 32'h3FFF, 32'h1FF};
        for (int i = 0; i < 4; i++) rd(ttm_spr_t'(i), 32'h0, 1);
        `CHK(fetchGrant, 1'b1)
        for (int i = 0; i < 4; i++) begin
            wr(ttm_spr_t'(i), 32'hFFFFFFFF, 1);
            rd(ttm_spr_t'(i), msk[i], 1);
            wr(ttm_spr_t'(i), 32'h0, 1);
        end
        wr(TTM_SEL_CTL, 32'h3, 0);
        rd(TTM_SEL_CTL, 32'h0, 1);
        wr(TTM_SEL_A, 32'h283, 0);
        rd(TTM_SEL_A, 32'h0, 1);
        wr(TTM_SEL_A, 32'h283, 1);
        rd(TTM_SEL_A, 32'h0, 0);
    endtask
    task automatic t_single();
        int n;
        temperature = 7'h32;
        wr(TTM_SEL_CTL, 32'h3, 1);
        n = excCount;
        for (int i = 0; i < 20 && excCount == n; i++) @(negedge clk);
        `CHK(excCount > n, 1'b1)
        `CHK(dacCode, 7'h28)
        rd(TTM_SEL_A, 32'hC0000283, 1);
        wr(TTM_SEL_A, 32'h3C3, 1);
        n = excCount;
        repeat (12) @(negedge clk);
        rd(TTM_SEL_A, 32'h400003C3, 1);
        `CHK(excCount, n)
        // Direction set: junction below the threshold counts as beyond it
        wr(TTM_SEL_A, 32'h3C5, 1);
        repeat (12) @(negedge clk);
        rd(TTM_SEL_A, 32'hC00003C5, 1);
    endtask
    task automatic t_dual();
        logic sa = 0, sb = 0;
        int n;
        wr(TTM_SEL_A, 32'h281, 1);
        n = excCount;
        wr(TTM_SEL_B, 32'h3C1, 1);
        repeat (24) @(negedge clk) begin
            sa |= (dacCode === 7'h28);
            sb |= (dacCode === 7'h3C);
        end
        `CHK({sa, sb}, 2'b11)
        rd(TTM_SEL_A, 32'hC0000281, 1);
        rd(TTM_SEL_B, 32'h400003C1, 1);
        `CHK(excCount, n)
    endtask
    task automatic t_disable();
        int n;
        wr(TTM_SEL_CTL, 32'h0, 1);
        wr(TTM_SEL_A, 32'h283, 1);
        n = excCount;
        repeat (30) @(negedge clk);
        `CHK(excCount, n)
        rd(TTM_SEL_A, 32'h283, 1);
    endtask
    task automatic t_throttle();
        int g = 0;
        wr(TTM_SEL_THROT, 32'h7, 1);
        repeat (40) @(negedge clk) g += (fetchGrant === 1'b1);
        `CHK(g, 10)
        wr(TTM_SEL_THROT, 32'h0, 1);
        @(negedge clk) `CHK(fetchGrant, 1'b1)
    endtask
    initial begin
        #20000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1;
        repeat (4) @(negedge clk);
        t_access();
        t_single();
        t_dual();
        t_disable();
        t_throttle();
        finish_test();
    end
endmodule
